// ---- scd_cfg.svh ----
// register map, field positions and reset values of the spi receive/delay block
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH

// register offsets (byte addresses)
`define SCD_OFF_RXBUF 8'h00
`define SCD_OFF_MIRROR 8'h04
`define SCD_OFF_DELAY 8'h08
`define SCD_OFF_TXDATA 8'h0C
`define SCD_OFF_CTRL 8'h10
`define SCD_OFF_IRQ_STAT 8'h14
`define SCD_OFF_IRQ_CLR 8'h18
`define SCD_OFF_IRQ_EN 8'h1C

// receive buffer status fields
`define SCD_RX_EMPTY_BIT 31
`define SCD_RX_OVR_BIT 30
`define SCD_RX_BERR_BIT 28
`define SCD_RX_LCS_HI 17
`define SCD_RX_LCS_LO 16
`define SCD_RX_DATA_HI 15

// delay register fields
`define SCD_C2T_HI 28
`define SCD_C2T_LO 24
`define SCD_T2C_HI 20
`define SCD_T2C_LO 16
`define SCD_C2T_MIN 5'h02
`define SCD_HOLD_EXTRA 5'h01

// transmit data and control fields
`define SCD_TX_SEL_HI 17
`define SCD_TX_SEL_LO 16
`define SCD_CTRL_LEN_HI 4
`define SCD_CTRL_BUSY_BIT 8
`define SCD_WORD_BITS 5'h10
`define SCD_LEN_RST 5'h10

// interrupt status bits
`define SCD_IRQ_BERR 0
`define SCD_IRQ_RX 1
`define SCD_IRQ_OVR 2

// select lines
`define SCD_SEL_IDLE 4'hF
`define SCD_SEL_ONE 4'h1

`endif

// ---- scd_pkg.sv ----
// types shared by the spi receive/delay block
package scd_pkg;

    typedef enum logic [1:0] {
        SCD_IDLE = 2'b00,
        SCD_SETUP = 2'b01,
        SCD_SHIFT = 2'b10,
        SCD_HOLD = 2'b11
    } scd_phase_e;

    typedef logic [4:0] scd_cnt_t;

    typedef struct packed {
        scd_cnt_t cnt;
        logic done;
    } scd_dly_s;

    typedef struct packed {
        scd_phase_e phase;
        logic lclk_s1, lclk_s2, lclk_d;
        logic din_s1, din_s2;
        logic echo_s1, echo_s2;
        logic driven;
        scd_cnt_t bit_cnt;
        logic [15:0] tx_shift;
        logic [15:0] rx_shift;
        logic [15:0] rx_data;
        logic [1:0] last_sel;
        logic [1:0] cur_sel;
        logic rx_empty, rx_ovr, berr_copy;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
        scd_cnt_t c2t, t2c, char_len;
        logic mo;
        logic [3:0] select_n;
        logic irq;
        logic [31:0] hrdata;
        logic hreadyout, hresp;
        logic dph_wr;
        logic [7:0] dph_addr;
    } scd_state_s;

endpackage : scd_pkg

// ---- scd_dly_if.sv ----
// load/expire handshake between the engine and its delay counter
`timescale 1ns/10ps
`default_nettype none
interface scd_dly_if;
    logic load;
    scd_pkg::scd_cnt_t value;
    logic done;
    modport ctl (output load, output value, input done);
    modport cnt (input load, input value, output done);
endinterface : scd_dly_if
`default_nettype wire

// ---- scd_delay_counter.sv ----
// peripheral-clock down-counter for select setup and hold delays
`timescale 1ns/10ps
`default_nettype none
module scd_delay_counter (
    input wire logic hclk,
    input wire logic hresetn,
    scd_dly_if.cnt dly
);
    import scd_pkg::*;

    scd_dly_s r_r;
    scd_dly_s r_nxt;

    // load on request, count down, pulse done as the count expires
    always_comb begin
        r_nxt = r_r;
        r_nxt.done = 1'b0;
        if (dly.load) begin
            r_nxt.cnt = dly.value;
        end else if (r_r.cnt != '0) begin
            r_nxt.cnt = r_r.cnt - 5'h01;
            r_nxt.done = (r_r.cnt == 5'h01);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign dly.done = r_r.done;
endmodule : scd_delay_counter
`default_nettype wire

// ---- scd_spi_core.sv ----
// spi transfer engine with receive status word, mirror and select delays
// How it works
// - sample own transmit pin at receive point
// - bit 28 error copy, cleared on read
// - enabled bit error raises interrupt request
// - last select number copied at write-back
// - received data right-justified in bits 15-0
// - reserved bits read zero, writes ignored
// - mirror returns data without clearing flags
// - setup delay 2 to 31 cycles
// - hold delay keeps select after last bit
// - hold time is field plus one, saturating at 31
// - empty set on read, cleared on copy
// - overrun on copy while not empty
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "scd_cfg.svh"
module scd_spi_core (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic link_clk,
    input wire logic slave_out_line,
    input wire logic master_out_echo,
    output logic master_out_line,
    output logic [3:0] select_n,
    output logic irq
);
    import scd_pkg::*;

    scd_state_s r_r;
    scd_state_s r_nxt;
    scd_dly_if dly ();
    logic ap_rd;
    logic rise;
    logic fall;
    scd_cnt_t shamt;
    logic [31:0] rxbuf_word;

    scd_delay_counter u_delay (
        .hclk(hclk),
        .hresetn(hresetn),
        .dly(dly)
    );

    // status word as software sees it
    always_comb begin
        rxbuf_word = '0;
        rxbuf_word[`SCD_RX_EMPTY_BIT] = r_r.rx_empty;
        rxbuf_word[`SCD_RX_OVR_BIT] = r_r.rx_ovr;
        rxbuf_word[`SCD_RX_BERR_BIT] = r_r.berr_copy;
        rxbuf_word[`SCD_RX_LCS_HI:`SCD_RX_LCS_LO] = r_r.last_sel;
        rxbuf_word[`SCD_RX_DATA_HI:0] = r_r.rx_data;
    end

    // next-state logic: bus side first, engine events after so sets win
    always_comb begin
        r_nxt = r_r;
        dly.load = 1'b0;
        dly.value = '0;
        ap_rd = hsel && htrans[1] && hready && !hwrite;
        rise = !r_r.lclk_d && r_r.lclk_s2;
        fall = r_r.lclk_d && !r_r.lclk_s2;
        shamt = `SCD_WORD_BITS - r_r.char_len;
        // two-flop synchronisers for pins and link clock
        r_nxt.lclk_s1 = link_clk;
        r_nxt.lclk_s2 = r_r.lclk_s1;
        r_nxt.lclk_d = r_r.lclk_s2;
        r_nxt.din_s1 = slave_out_line;
        r_nxt.din_s2 = r_r.din_s1;
        r_nxt.echo_s1 = master_out_echo;
        r_nxt.echo_s2 = r_r.echo_s1;
        r_nxt.hreadyout = 1'b1;
        r_nxt.hresp = 1'b0;
        // address phase: capture writes, answer reads
        r_nxt.dph_wr = hsel && htrans[1] && hready && hwrite;
        r_nxt.dph_addr = haddr[7:0];
        if (ap_rd) begin
            r_nxt.hrdata = '0;
            case (haddr[7:0])
                `SCD_OFF_RXBUF: begin
                    r_nxt.hrdata = rxbuf_word;
                    r_nxt.rx_empty = 1'b1;
                    r_nxt.rx_ovr = 1'b0;
                    r_nxt.berr_copy = 1'b0;
                    r_nxt.irq_stat[`SCD_IRQ_RX] = 1'b0;
                    r_nxt.irq_stat[`SCD_IRQ_OVR] = 1'b0;
                end
                `SCD_OFF_MIRROR: begin
                    r_nxt.hrdata[`SCD_RX_DATA_HI:0] = r_r.rx_data;
                end
                `SCD_OFF_DELAY: begin
                    r_nxt.hrdata[`SCD_C2T_HI:`SCD_C2T_LO] = r_r.c2t;
                    r_nxt.hrdata[`SCD_T2C_HI:`SCD_T2C_LO] = r_r.t2c;
                end
                `SCD_OFF_CTRL: begin
                    r_nxt.hrdata[`SCD_CTRL_LEN_HI:0] = r_r.char_len;
                    r_nxt.hrdata[`SCD_CTRL_BUSY_BIT] = (r_r.phase != SCD_IDLE);
                end
                `SCD_OFF_IRQ_STAT: begin
                    r_nxt.hrdata[2:0] = r_r.irq_stat;
                end
                `SCD_OFF_IRQ_EN: begin
                    r_nxt.hrdata[2:0] = r_r.irq_en;
                end
                default: begin
                    r_nxt.hrdata = '0;
                end
            endcase
        end
        // data phase: apply the captured write
        if (r_r.dph_wr) begin
            case (r_r.dph_addr)
                `SCD_OFF_DELAY: begin
                    r_nxt.c2t = hwdata[`SCD_C2T_HI:`SCD_C2T_LO];
                    r_nxt.t2c = hwdata[`SCD_T2C_HI:`SCD_T2C_LO];
                end
                `SCD_OFF_CTRL: begin
                    if (hwdata[`SCD_CTRL_LEN_HI:0] == '0 ||
                        hwdata[`SCD_CTRL_LEN_HI:0] > `SCD_WORD_BITS) begin
                        r_nxt.char_len = `SCD_WORD_BITS;
                    end else begin
                        r_nxt.char_len = hwdata[`SCD_CTRL_LEN_HI:0];
                    end
                end
                `SCD_OFF_IRQ_CLR: begin
                    r_nxt.irq_stat = r_r.irq_stat & ~hwdata[2:0];
                end
                `SCD_OFF_IRQ_EN: begin
                    r_nxt.irq_en = hwdata[2:0];
                end
                `SCD_OFF_TXDATA: begin
                    if (r_r.phase == SCD_IDLE) begin
                        r_nxt.cur_sel = hwdata[`SCD_TX_SEL_HI:`SCD_TX_SEL_LO];
                        r_nxt.tx_shift = hwdata[`SCD_RX_DATA_HI:0] << shamt;
                        r_nxt.rx_shift = '0;
                        r_nxt.bit_cnt = '0;
                        r_nxt.driven = 1'b0;
                        r_nxt.select_n = ~(`SCD_SEL_ONE << hwdata[`SCD_TX_SEL_HI:`SCD_TX_SEL_LO]);
                        dly.load = 1'b1;
                        dly.value = (r_r.c2t < `SCD_C2T_MIN) ? `SCD_C2T_MIN : r_r.c2t;
                        r_nxt.phase = SCD_SETUP;
                    end
                end
                default: begin
                    r_nxt.hrdata = r_nxt.hrdata;
                end
            endcase
        end
        // transfer engine
        case (r_r.phase)
            SCD_IDLE: begin
                r_nxt.phase = r_nxt.phase;
            end
            SCD_SETUP: begin
                if (dly.done) begin
                    r_nxt.phase = SCD_SHIFT;
                end
            end
            SCD_SHIFT: begin
                if (fall) begin
                    r_nxt.mo = r_r.tx_shift[`SCD_RX_DATA_HI]; // transmit point
                    r_nxt.driven = 1'b1;
                end else if (rise && r_r.driven) begin
                    if (r_r.echo_s2 != r_r.mo) begin
                        r_nxt.irq_stat[`SCD_IRQ_BERR] = 1'b1;
                        r_nxt.berr_copy = 1'b1;
                    end
                    r_nxt.rx_shift = {r_r.rx_shift[14:0], r_r.din_s2};
                    r_nxt.tx_shift = {r_r.tx_shift[14:0], 1'b0};
                    r_nxt.bit_cnt = r_r.bit_cnt + 5'h01;
                    r_nxt.driven = 1'b0;
                    if (r_r.bit_cnt + 5'h01 == r_r.char_len) begin
                        // write-back of the finished character
                        r_nxt.rx_data = {r_r.rx_shift[14:0], r_r.din_s2};
                        r_nxt.last_sel = r_r.cur_sel;
                        r_nxt.rx_empty = 1'b0;
                        r_nxt.irq_stat[`SCD_IRQ_RX] = 1'b1;
                        if (!r_nxt.rx_empty || !r_r.rx_empty) begin
                            r_nxt.rx_ovr = !r_r.rx_empty ? 1'b1 : r_nxt.rx_ovr;
                            r_nxt.irq_stat[`SCD_IRQ_OVR] =
                                !r_r.rx_empty ? 1'b1 : r_nxt.irq_stat[`SCD_IRQ_OVR];
                        end
                        dly.load = 1'b1;
                        // saturate so an all-ones field cannot wrap to a dead zero load
                        dly.value = (&r_r.t2c) ? r_r.t2c : r_r.t2c + `SCD_HOLD_EXTRA;
                        r_nxt.phase = SCD_HOLD;
                    end
                end
            end
            SCD_HOLD: begin
                if (dly.done) begin
                    r_nxt.select_n = `SCD_SEL_IDLE;
                    r_nxt.phase = SCD_IDLE;
                end
            end
            default: begin
                r_nxt.phase = SCD_IDLE;
            end
        endcase
        // level interrupt from enabled sticky bits
        r_nxt.irq = |(r_nxt.irq_stat & r_nxt.irq_en);
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_r <= '0;
            r_r.phase <= SCD_IDLE;
            r_r.select_n <= `SCD_SEL_IDLE;
            r_r.rx_empty <= 1'b1;
            r_r.hreadyout <= 1'b1;
            r_r.char_len <= `SCD_LEN_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // outputs straight from the state register
    assign hrdata = r_r.hrdata;
    assign hreadyout = r_r.hreadyout;
    assign hresp = r_r.hresp;
    assign master_out_line = r_r.mo;
    assign select_n = r_r.select_n;
    assign irq = r_r.irq;
endmodule : scd_spi_core
`default_nettype wire

// ---- scd_spi_core_chk.sv ----
// port assertions for the spi receive status and select delay block
`timescale 1ns/10ps
`default_nettype none
module scd_spi_core_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic link_clk,
    input wire logic master_out_line,
    input wire logic [3:0] select_n
);
    logic rd_q;
    logic rx_rd;
    logic seen_r;
    logic [7:0] a_q;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // read data phase tracking; seen_r marks an rx read with no frame since
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            a_q <= 8'h00;
            seen_r <= 1'b0;
        end else begin
            rd_q <= hsel && htrans[1] && hready && !hwrite;
            a_q <= haddr[7:0];
            seen_r <= (select_n != 4'hF) ? 1'b0 : (rx_rd ? 1'b1 : seen_r);
        end
    end
    assign rx_rd = rd_q && (a_q == 8'h00);
    // select goes active, link clock rises inside a frame
    sequence s_sel_on;
        (select_n != 4'hF) && ($past(select_n) == 4'hF);
    endsequence
    sequence s_rise_sel;
        $rose(link_clk) && (select_n != 4'hF);
    endsequence
    a_rx_reserved_zero: assert property (rx_rd |-> hrdata[27:18] == 10'h000)
        else $error("rx status reserved bits not zero");
    a_mirror_upper_zero: assert property (rd_q && a_q == 8'h04 |-> hrdata[31:16] == 16'h0000)
        else $error("mirror upper half not zero");
    a_delay_gaps_zero: assert property (rd_q && a_q == 8'h08 |-> (hrdata & 32'hE0E0_FFFF) == 0)
        else $error("delay reserved bits not zero");
    a_empty_on_reread: assert property (rx_rd && seen_r |-> hrdata[31])
        else $error("empty flag not set after read");
    a_overrun_read_clear: assert property (rx_rd && seen_r |-> !hrdata[30])
        else $error("overrun flag survived a read");
    a_bit_err_clear: assert property (rx_rd && seen_r |-> !hrdata[28])
        else $error("bit error copy survived a read");
    a_setup_no_data: assert property (s_sel_on |-> $stable(master_out_line)[*2])
        else $error("data moved during select setup");
    a_select_min_low: assert property (s_sel_on |-> (select_n != 4'hF)[*3])
        else $error("select released during setup");
    a_hold_after_rise: assert property (s_rise_sel |=> (select_n != 4'hF)[*3])
        else $error("select released too soon after bit");
endmodule : scd_spi_core_chk
bind scd_spi_core scd_spi_core_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .link_clk(link_clk), .master_out_line(master_out_line), .select_n(select_n));
`default_nettype wire

// ---- scd_link_model.sv ----
// far-side serial device: frame clock, reply bits and capture of our bits
`timescale 1ns/10ps
`default_nettype none
module scd_link_model (
    input wire logic [3:0] select_n,
    input wire logic master_out_line,
    input wire logic [4:0] nbits,
    input wire logic [15:0] tx_word,
    output logic link_clk,
    output logic slave_out_line,
    output logic [15:0] rx_word
);
    // clock only inside a frame, released line shows the inverse level
    initial begin
        link_clk = 1'b1;
        slave_out_line = 1'b0;
        rx_word = 16'h0000;
        forever begin
            @(negedge (&select_n));
            #161;
            for (int i = int'(nbits) - 1; i >= 0; i--) begin
                link_clk = 1'b0;
                #3 slave_out_line = tx_word[i];
                #29 link_clk = 1'b1;
                rx_word = {rx_word[14:0], master_out_line};
                #32;
            end
            wait (&select_n); // a short hold can end before the last half period does
            slave_out_line = ~slave_out_line;
        end
    end
endmodule : scd_link_model
`default_nettype wire

// ---- scd_spi_core_tb_top.sv ----
// self-checking bench for the spi receive status and select delay block
`timescale 1ns/10ps
`default_nettype none
module scd_spi_core_tb_top;
    logic hclk, hresetn, hsel, hwrite, err_inj, hreadyout, hresp, link_clk;
    logic slave_out_line, master_out_line, irq;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [15:0] rx_word, tx_word;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] select_n;
    logic [4:0] nbits;
    wire logic hready = hreadyout;
    wire logic echo = master_out_line ^ err_inj;
    int failures, n_tests, cyc;
    realtime t_rise, th, t_h0;
    scd_spi_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk),
        .slave_out_line(slave_out_line), .master_out_echo(echo),
        .master_out_line(master_out_line), .select_n(select_n), .irq(irq));
    scd_link_model u_far (.select_n(select_n), .master_out_line(master_out_line),
        .nbits(nbits), .tx_word(tx_word), .link_clk(link_clk),
        .slave_out_line(slave_out_line), .rx_word(rx_word));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // hang guard and last link rise time
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            conclude();
        end
    end
    always @(posedge link_clk) t_rise = $realtime;
    task automatic conclude();
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    // one single-word bus transfer, read data kept in q
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : ahb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask : rc
    // one frame: start, wait for select on and off, note the hold time
    task automatic xfer(input logic [1:0] s, input logic [15:0] d, input logic [15:0] so);
        tx_word <= so;
        ahb(1'b1, 8'h0C, {14'h0000, s, d});
        @(posedge hclk iff select_n != 4'hF);
        @(posedge hclk iff select_n == 4'hF);
        th = $realtime - t_rise;
    endtask : xfer
    // main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        err_inj = 1'b0;
        nbits = 5'h08;
        tx_word = 16'h0000;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({30'h0000_0000, hreadyout, hresp}, 32'h0000_0002); // okay answer, no wait
        rc(8'h00, 32'h8000_0000);
        rc(8'h08, 32'h0000_0000);
        ahb(1'b1, 8'h08, 32'hFFFF_0000);
        rc(8'h08, 32'h1F1F_0000);
        ahb(1'b1, 8'h08, 32'h0000_0000);
        ahb(1'b1, 8'h10, 32'h0000_0008);
        ahb(1'b1, 8'h1C, 32'h0000_0003);
        xfer(2'h2, 16'h00A5, 16'h003C);
        t_h0 = th;
        chk({16'h0000, rx_word}, 32'h0000_00A5);
        rc(8'h04, 32'h0000_003C);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        rc(8'h00, 32'h0002_003C);
        ahb(1'b1, 8'h08, 32'h1616_0000);
        ahb(1'b1, 8'h10, 32'h0000_0010);
        nbits <= 5'h10;
        xfer(2'h1, 16'h1234, 16'hBEEF);
        xfer(2'h1, 16'h1234, 16'hBEEF);
        chk(32'(int'(th - t_h0)), 32'h0000_0058);
        rc(8'h00, 32'h4001_BEEF);
        rc(8'h00, 32'h8001_BEEF);
        ahb(1'b1, 8'h1C, 32'h0000_0001);
        err_inj <= 1'b1;
        xfer(2'h3, 16'h0F0F, 16'h0000);
        err_inj <= 1'b0;
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        rc(8'h00, 32'h1003_0000);
        rc(8'h00, 32'h8003_0000);
        ahb(1'b1, 8'h18, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rc(8'h20, 32'h0000_0000);
        conclude();
    end
endmodule : scd_spi_core_tb_top
`default_nettype wire
